// ---- rtl/pctl_pkg.sv ----
// Constants for the port pin control and interrupt block
// Functional notes
// - Every one of the 32 port pins owns its own pin control register.
// - Upper half holds interrupt detection mode and the pin interrupt flag.
// - Lower half sets pull, drive, slew, passive filter and mux mode.
// - Pad settings apply in every digital mux mode; peripherals never override them.
// - Mux mode analog/disabled turns off pulls and filter; slew and drive still follow the register.
// - Pin control contents survive disabling the port module.
// - One global write loads a common lower half into up to sixteen pins.
// - Global writes never touch interrupt mode or flag bits.
// - Both global registers are write-only and read as zero.
// - Interrupt detection works in digital mux modes only while module enabled.
// - Modes: disabled (reset), high level, low level, rising, falling, both edges.
// - Flag sets whenever the configured edge or level is detected.
// - Outside stop mode pins are synchronised to the bus clock first.
// - One combined interrupt asserts while any enabled pin flag is set.
// - Writing 1 clears a flag in either register; interrupt drops when all clear.
// - In stop mode enabled edge events are captured asynchronously without a clock.
// - A stop-mode asynchronous set also raises an asynchronous wakeup.
// - Level interrupt with pin still asserted sets the flag again after clearing.
// - Global low selects pins 15..0 by bits 31..16; high does pins 31..16.
package pctl_pkg;
    localparam int          PCTL_PINS        = 32;
    // Byte addresses
    localparam logic [7:0]  PCTL_PIN_BASE    = 8'h00;
    localparam logic [7:0]  PCTL_GLOBAL_LOW  = 8'h80;
    localparam logic [7:0]  PCTL_GLOBAL_HIGH = 8'h84;
    localparam logic [7:0]  PCTL_FLAG_ADDR   = 8'hA0;
    localparam logic [7:0]  PCTL_CTRL_ADDR   = 8'hC0;
    // Pin control register fields
    localparam int          PCTL_PULL_DIR    = 0;
    localparam int          PCTL_PULL_EN     = 1;
    localparam int          PCTL_SLEW        = 2;
    localparam int          PCTL_FILTER      = 4;
    localparam int          PCTL_DRIVE       = 6;
    localparam int          PCTL_MUX_LSB     = 8;
    localparam int          PCTL_MUX_W       = 3;
    localparam int          PCTL_IRQC_LSB    = 16;
    localparam int          PCTL_FLAG_BIT    = 24;
    localparam int          PCTL_GSEL_LSB    = 16;
    localparam logic [15:0] PCTL_LOW_MASK    = 16'h0757;
    localparam logic [15:0] PCTL_LOW_RESET   = 16'h0000;
    localparam logic [2:0]  PCTL_MUX_ANALOG  = 3'h0;
    localparam logic        PCTL_ENABLE_RST  = 1'b1;
    // Interrupt modes
    localparam logic [3:0]  PCTL_IRQ_OFF     = 4'h0;
    localparam logic [3:0]  PCTL_IRQ_LOW     = 4'h8;
    localparam logic [3:0]  PCTL_IRQ_RISE    = 4'h9;
    localparam logic [3:0]  PCTL_IRQ_FALL    = 4'hA;
    localparam logic [3:0]  PCTL_IRQ_BOTH    = 4'hB;
    localparam logic [3:0]  PCTL_IRQ_HIGH    = 4'hC;
    localparam logic [1:0]  PCTL_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  PCTL_RESP_SLVERR = 2'h2;
endpackage

// ---- rtl/pctl_pin_detect.sv ----
// Per-pin synchroniser, edge/level detector and stop-mode capture
`timescale 1ns/100ps
module pctl_pin_detect
    import pctl_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       pinIn,
    input  wire logic [3:0] mode,
    input  wire logic       armed,
    input  wire logic       stopMode,
    input  wire logic       capClr,
    output logic            hit,
    output logic            stopHit,
    output logic            wake
);
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic cap1;
        logic cap2;
    } pctl_det_type;

    pctl_det_type det_r;
    pctl_det_type det_nxt;
    logic         capRise;
    logic         capFall;
    logic         capRst;
    logic         isHigh;
    logic         isLow;
    logic         isRise;
    logic         isFall;

    assign isHigh = (mode == PCTL_IRQ_HIGH);
    assign isLow  = (mode == PCTL_IRQ_LOW);
    assign isRise = (mode == PCTL_IRQ_RISE) || (mode == PCTL_IRQ_BOTH);
    assign isFall = (mode == PCTL_IRQ_FALL) || (mode == PCTL_IRQ_BOTH);
    // capClr is a flop output, so no glitch reaches the async clear
    assign capRst = rst | capClr;

    ////////////////////////////////////////////////////////////////////////
    // Clockless edge capture while the bus clock is stopped
    always_ff @(posedge pinIn or posedge capRst) begin
        if (capRst) begin
            capRise <= 1'b0;
        end else if (armed && stopMode && isRise) begin
            capRise <= 1'b1;
        end
    end

    always_ff @(negedge pinIn or posedge capRst) begin
        if (capRst) begin
            capFall <= 1'b0;
        end else if (armed && stopMode && isFall) begin
            capFall <= 1'b1;
        end
    end

    // Raw level path needs no clock to wake the system
    assign wake = armed && stopMode && (capRise || capFall ||
                  (isHigh && pinIn) || (isLow && !pinIn));

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        det_nxt       = det_r;
        det_nxt.sync1 = pinIn;
        det_nxt.sync2 = det_r.sync1;
        det_nxt.prev  = det_r.sync2;
        det_nxt.cap1  = capRise | capFall;
        det_nxt.cap2  = det_r.cap1;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            det_r <= '0;
        end else begin
            det_r <= det_nxt;
        end
    end

    assign hit = armed && ((isHigh && det_r.sync2) || (isLow && !det_r.sync2) ||
                 (isRise && det_r.sync2 && !det_r.prev) ||
                 (isFall && !det_r.sync2 && det_r.prev));
    assign stopHit = det_r.cap2;
endmodule

// ---- rtl/pctl_port.sv ----
// Port pin control registers, global writes and pin interrupts over AXI4-Lite
`timescale 1ns/100ps
module pctl_port
    import pctl_pkg::*;
#(
    parameter int PINS = PCTL_PINS
)
(
    input  wire logic                        clk,
    input  wire logic                        rst,
    // AXI4-Lite slave
    input  wire logic [7:0]                  awaddr,
    input  wire logic                        awvalid,
    output logic                             awready,
    input  wire logic [31:0]                 wdata,
    input  wire logic [3:0]                  wstrb,
    input  wire logic                        wvalid,
    output logic                             wready,
    output logic [1:0]                       bresp,
    output logic                             bvalid,
    input  wire logic                        bready,
    input  wire logic [7:0]                  araddr,
    input  wire logic                        arvalid,
    output logic                             arready,
    output logic [31:0]                      rdata,
    output logic [1:0]                       rresp,
    output logic                             rvalid,
    input  wire logic                        rready,
    // Pins and system
    input  wire logic [PINS-1:0]             pinIn,
    input  wire logic                        stopMode,
    output logic [PINS-1:0]                  padPullEnable,
    output logic [PINS-1:0]                  padPullUp,
    output logic [PINS-1:0]                  padSlewSlow,
    output logic [PINS-1:0]                  padFilter,
    output logic [PINS-1:0]                  padDriveHigh,
    output logic [PINS*PCTL_MUX_W-1:0]       muxSel,
    output logic                             portIrq,
    output logic                             wakeup
);
    typedef struct packed {
        logic [PINS-1:0][15:0] low;
        logic [PINS-1:0][3:0]  irqc;
        logic [PINS-1:0]       flag;
        logic [PINS-1:0]       capClr;
        logic                  enable;
        logic                  awHeld;
        logic [7:0]            awAddr;
        logic                  wHeld;
        logic [31:0]           wData;
        logic [3:0]            wStrb;
        logic                  bValid;
        logic [1:0]            bResp;
        logic                  rValid;
        logic [31:0]           rData;
        logic [1:0]            rResp;
        logic                  irq;
    } pctl_state_type;

    pctl_state_type st_r;
    pctl_state_type st_nxt;
    logic [PINS-1:0] hit;
    logic [PINS-1:0] stopHit;
    logic [PINS-1:0] pinWake;
    logic [PINS-1:0] armed;
    logic [PINS-1:0] digital;
    logic [PINS-1:0] irqOn;

    ////////////////////////////////////////////////////////////////////////
    // Per-pin detectors and pad outputs
    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : gPin
            assign digital[g] = st_r.low[g][PCTL_MUX_LSB +: PCTL_MUX_W] != PCTL_MUX_ANALOG;
            assign irqOn[g]   = st_r.irqc[g] != PCTL_IRQ_OFF;
            assign armed[g]   = st_r.enable && digital[g] && irqOn[g];

            pctl_pin_detect uDet (
                .clk      (clk),
                .rst      (rst),
                .pinIn    (pinIn[g]),
                .mode     (st_r.irqc[g]),
                .armed    (armed[g]),
                .stopMode (stopMode),
                .capClr   (st_r.capClr[g]),
                .hit      (hit[g]),
                .stopHit  (stopHit[g]),
                .wake     (pinWake[g])
            );

            // Pad settings hold in every digital mux; no peripheral input here
            assign padPullEnable[g] = digital[g] && st_r.low[g][PCTL_PULL_EN];
            assign padPullUp[g]     = digital[g] && st_r.low[g][PCTL_PULL_DIR];
            assign padFilter[g]     = digital[g] && st_r.low[g][PCTL_FILTER];
            assign padSlewSlow[g]   = st_r.low[g][PCTL_SLEW];
            assign padDriveHigh[g]  = st_r.low[g][PCTL_DRIVE];
            assign muxSel[g*PCTL_MUX_W +: PCTL_MUX_W] = st_r.low[g][PCTL_MUX_LSB +: PCTL_MUX_W];
        end
    endgenerate

    // Async path; only pins armed in stop mode can drive it
    assign wakeup = |pinWake;

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake outputs
    assign awready = !st_r.awHeld;
    assign wready  = !st_r.wHeld;
    assign bvalid  = st_r.bValid;
    assign bresp   = st_r.bResp;
    assign arready = !st_r.rValid;
    assign rvalid  = st_r.rValid;
    assign rdata   = st_r.rData;
    assign rresp   = st_r.rResp;
    assign portIrq = st_r.irq;

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic [PINS-1:0] swClr;
        logic [PINS-1:0] setFlag;
        logic [31:0]     rd;
        logic [1:0]      rsp;
        logic [5:0]      idx;
        logic            doWrite;
        logic            isPin;
        logic            full;
        logic [15:0]     gVal;
        logic [15:0]     gSel;
        logic [31:0]     wmask;
        swClr   = '0;
        setFlag = '0;
        rd      = '0;
        rsp     = PCTL_RESP_OKAY;
        idx     = '0;
        isPin   = 1'b0;
        doWrite = 1'b0;
        full    = 1'b0;
        gVal    = '0;
        gSel    = '0;
        wmask   = '0;
        st_nxt  = st_r;

        for (int b = 0; b < 4; b++) begin
            wmask[b*8 +: 8] = {8{st_r.wStrb[b]}};
        end
        full = (st_r.wStrb == 4'hF);
        gVal = st_r.wData[15:0];
        gSel = st_r.wData[31:PCTL_GSEL_LSB];

        // Write channels are taken independently
        if (awvalid && !st_r.awHeld) begin
            st_nxt.awHeld = 1'b1;
            st_nxt.awAddr = awaddr;
        end
        if (wvalid && !st_r.wHeld) begin
            st_nxt.wHeld = 1'b1;
            st_nxt.wData = wdata;
            st_nxt.wStrb = wstrb;
        end
        if (st_r.bValid && bready) begin
            st_nxt.bValid = 1'b0;
        end

        // Write executes once both halves are held and no response pends
        doWrite = st_r.awHeld && st_r.wHeld && !st_r.bValid;
        if (doWrite) begin
            st_nxt.awHeld = 1'b0;
            st_nxt.wHeld  = 1'b0;
            st_nxt.bValid = 1'b1;
            st_nxt.bResp  = PCTL_RESP_OKAY;
            idx   = st_r.awAddr[7:2];
            isPin = st_r.awAddr < PCTL_GLOBAL_LOW;
            if (isPin) begin
                for (int p = 0; p < PINS; p++) begin
                    if (idx == 6'(p)) begin
                        st_nxt.low[p] = (st_r.low[p] & ~(wmask[15:0] & PCTL_LOW_MASK)) |
                                        (st_r.wData[15:0] & wmask[15:0] & PCTL_LOW_MASK);
                        if (st_r.wStrb[2]) begin
                            st_nxt.irqc[p] = st_r.wData[PCTL_IRQC_LSB +: 4];
                        end
                        swClr[p] = st_r.wStrb[3] && st_r.wData[PCTL_FLAG_BIT];
                    end
                end
            end else if (st_r.awAddr == PCTL_GLOBAL_LOW || st_r.awAddr == PCTL_GLOBAL_HIGH) begin
                // Narrow writes dropped; upper half never written here
                for (int p = 0; p < 16; p++) begin
                    if (full && gSel[p]) begin
                        if (st_r.awAddr == PCTL_GLOBAL_LOW) begin
                            st_nxt.low[p] = gVal & PCTL_LOW_MASK;
                        end else begin
                            st_nxt.low[p+16] = gVal & PCTL_LOW_MASK;
                        end
                    end
                end
            end else if (st_r.awAddr == PCTL_FLAG_ADDR) begin
                swClr = PINS'(st_r.wData & wmask);
            end else if (st_r.awAddr == PCTL_CTRL_ADDR) begin
                // Disabling only stops detection; configuration is kept
                if (st_r.wStrb[0]) begin
                    st_nxt.enable = st_r.wData[0];
                end
            end else begin
                st_nxt.bResp = PCTL_RESP_SLVERR;
            end
        end

        // Read: one cycle from address to data
        if (st_r.rValid && rready) begin
            st_nxt.rValid = 1'b0;
        end
        if (arvalid && !st_r.rValid) begin
            idx = araddr[7:2];
            if (araddr < PCTL_GLOBAL_LOW) begin
                for (int p = 0; p < PINS; p++) begin
                    if (idx == 6'(p)) begin
                        rd[15:0] = st_r.low[p];
                        rd[PCTL_IRQC_LSB +: 4] = st_r.irqc[p];
                        rd[PCTL_FLAG_BIT] = st_r.flag[p];
                    end
                end
            end else if (araddr == PCTL_GLOBAL_LOW || araddr == PCTL_GLOBAL_HIGH) begin
                rd = '0;
            end else if (araddr == PCTL_FLAG_ADDR) begin
                rd = 32'(st_r.flag);
            end else if (araddr == PCTL_CTRL_ADDR) begin
                rd = {31'h0, st_r.enable};
            end else begin
                rsp = PCTL_RESP_SLVERR;
            end
            st_nxt.rValid = 1'b1;
            st_nxt.rData  = rd;
            st_nxt.rResp  = rsp;
        end

        // Flags: a detection in the same cycle as a clear wins
        setFlag = (hit | stopHit) & armed;
        st_nxt.flag   = (st_r.flag & ~swClr) | setFlag;
        // Release stop captures once seen or cleared by software
        st_nxt.capClr = swClr | stopHit;
        st_nxt.irq    = |(st_nxt.flag & irqOn);
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r        <= '0;
            st_r.low    <= {PINS{PCTL_LOW_RESET}};
            st_r.irqc   <= {PINS{PCTL_IRQ_OFF}};
            st_r.enable <= PCTL_ENABLE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule

// ---- tb/pctl_pin_model.sv ----
// Pin-side partner: pad levels seen by the port block
`timescale 1ns/100ps
module pctl_pin_model
    import pctl_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic [PCTL_PINS-1:0] want,
    output logic      [PCTL_PINS-1:0] pins
);
    initial pins = '0;
    // Pads switch after the edge, never on it
    always @(posedge clk) begin
        pins <= want;
    end
endmodule

// ---- tb/pctl_port_sva.sv ----
// Concurrent checks on the port block's bus, pad and interrupt outputs
`timescale 1ns/100ps
module pctl_port_sva
    import pctl_pkg::*;
#(
    parameter int PINS = PCTL_PINS
)
(
    input wire logic                      clk,
    input wire logic                      rst,
    input wire logic                      awvalid,
    input wire logic                      awready,
    input wire logic                      wvalid,
    input wire logic                      wready,
    input wire logic                      bvalid,
    input wire logic                      bready,
    input wire logic [1:0]                bresp,
    input wire logic [7:0]                araddr,
    input wire logic                      arvalid,
    input wire logic                      arready,
    input wire logic                      rvalid,
    input wire logic                      rready,
    input wire logic [31:0]               rdata,
    input wire logic                      stopMode,
    input wire logic [PINS-1:0]           padPullEnable,
    input wire logic [PINS-1:0]           padPullUp,
    input wire logic [PINS-1:0]           padFilter,
    input wire logic [PINS*PCTL_MUX_W-1:0] muxSel,
    input wire logic                      portIrq,
    input wire logic                      wakeup
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    logic [PINS-1:0] muxOff;
    logic [3:0]      sinceWr_r;
    logic            glbRd_r;
    always_comb begin
        for (int i = 0; i < PINS; i++) begin
            muxOff[i] = (muxSel[3*i +: 3] == 3'h0);
        end
    end
    // Saturates so a long idle spell never wraps into a false window
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sinceWr_r <= 4'hF;
            glbRd_r   <= 1'b0;
        end else begin
            if (awvalid && awready) sinceWr_r <= 4'h0;
            else if (sinceWr_r != 4'hF) sinceWr_r <= sinceWr_r + 4'h1;
            if (arvalid && arready) glbRd_r <= (araddr == PCTL_GLOBAL_LOW) || (araddr == PCTL_GLOBAL_HIGH);
        end
    end
    ////////////////////////////////////////
    sequence wrBoth;
        awvalid && awready && wvalid && wready && !bvalid;
    endsequence
    sequence rdTaken;
        arvalid && arready;
    endsequence
    pads_analog_a: assert property (((padPullEnable | padPullUp | padFilter) & muxOff) == '0)
        else $error("pad function active on analog pin");
    wake_stop_a: assert property (wakeup |-> stopMode)
        else $error("wakeup outside stop mode");
    write_answer_a: assert property (wrBoth |-> ##[1:3] bvalid)
        else $error("write response missing");
    bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    read_answer_a: assert property (rdTaken |=> rvalid)
        else $error("read data missing");
    rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped early");
    global_zero_a: assert property (rvalid && glbRd_r |-> rdata == 32'h0)
        else $error("global register read not zero");
    irq_fall_a: assert property ($fell(portIrq) |-> sinceWr_r <= 4'h6)
        else $error("interrupt dropped without a write");
    read_busy_a: assert property (rvalid |-> !arready)
        else $error("read accepted while data pending");
endmodule
bind pctl_port pctl_port_sva #(.PINS(PINS)) chk_u (
    .clk(clk), .rst(rst), .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata), .stopMode(stopMode),
    .padPullEnable(padPullEnable), .padPullUp(padPullUp), .padFilter(padFilter), .muxSel(muxSel),
    .portIrq(portIrq), .wakeup(wakeup)
);

// ---- tb/test_port_pin_control_irq.sv ----
// Self-checking bench for the port pin control and interrupt block
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; $display("ERROR %s exp %h got %h", n, e, g); end end
module test_port_pin_control_irq
    import pctl_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, stopMode = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, want = 32'h0, rv;
    logic [3:0]  wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, portIrq, wakeup;
    logic [1:0]  bresp, rresp, rr, wb;
    logic [31:0] rdata, pinIn, padPullEnable, padPullUp, padSlewSlow, padFilter, padDriveHigh;
    logic [95:0] muxSel;
    int bad_count = 0, checks_done = 0;
    localparam logic [3:0] MODES [5] = '{PCTL_IRQ_LOW, PCTL_IRQ_RISE, PCTL_IRQ_FALL, PCTL_IRQ_BOTH, PCTL_IRQ_HIGH};
    localparam logic [4:0] IDLE = 5'h05;
    localparam logic [4:0] LEVEL = 5'h11;
    always #12.5 clk = ~clk;
    pctl_port dut_u (
        .clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .pinIn(pinIn),
        .stopMode(stopMode), .padPullEnable(padPullEnable), .padPullUp(padPullUp),
        .padSlewSlow(padSlewSlow), .padFilter(padFilter), .padDriveHigh(padDriveHigh),
        .muxSel(muxSel), .portIrq(portIrq), .wakeup(wakeup)
    );
    pctl_pin_model pins_u (.clk(clk), .want(want), .pins(pinIn));
    ////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) break;
        end
        wb = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) break;
        end
        rv = rdata;
        rr = rresp;
        rready <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        `CHK("rdata", e, rv)
        `CHK("rresp", PCTL_RESP_OKAY, rr)
    endtask
    task automatic print_verdict;
        if (bad_count == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rc(PCTL_CTRL_ADDR, 32'h1);
        rc(8'h14, 32'h0);
        wr(8'h0C, 32'h0000_0713);
        `CHK("bresp", PCTL_RESP_OKAY, wb)
        rc(8'h0C, 32'h0000_0713);
        `CHK("pads", 4'hF, {padPullEnable[3], padPullUp[3], padFilter[3], muxSel[11:9] == 3'h7})
        wr(8'h0C, 32'h0009_0013);
        rc(8'h0C, 32'h0009_0013);
        `CHK("analog pads", 3'h0, {padPullEnable[3], padPullUp[3], padFilter[3]})
        // Full-word writes only: narrow global writes are not supported
        wr(PCTL_GLOBAL_LOW, 32'h000B_0146);
        rc(8'h0C, 32'h0009_0146);
        rc(8'h04, 32'h0000_0146);
        rc(8'h08, 32'h0);
        wr(PCTL_GLOBAL_HIGH, 32'h8000_0757);
        rc(8'h7C, 32'h0000_0757);
        `CHK("slew drive", 2'h3, {padSlewSlow[31], padDriveHigh[31]})
        rc(8'h3C, 32'h0);
        rc(PCTL_GLOBAL_LOW, 32'h0);
        rc(PCTL_GLOBAL_HIGH, 32'h0);
        rd(8'h90);
        `CHK("unmapped resp", PCTL_RESP_SLVERR, rr)
        wr(8'h90, 32'h1);
        `CHK("unmapped wresp", PCTL_RESP_SLVERR, wb)
        for (int i = 0; i < 5; i++) begin
            // Mode off first, else the old mode, level or edge, flags the idle move
            wr(8'h14, 32'h0000_0100);
            want[5] <= IDLE[i];
            repeat (6) @(posedge clk);
            wr(8'h14, {12'h010, MODES[i], 16'h0100});
            rc(PCTL_FLAG_ADDR, 32'h0);
            want[5] <= ~IDLE[i];
            repeat (6) @(posedge clk);
            rc(PCTL_FLAG_ADDR, 32'h20);
            `CHK("irq", 1'b1, portIrq)
            wr(PCTL_FLAG_ADDR, 32'h20);
            rc(PCTL_FLAG_ADDR, LEVEL[i] ? 32'h20 : 32'h0);
            want[5] <= IDLE[i];
            repeat (6) @(posedge clk);
            wr(8'h14, {12'h010, MODES[i], 16'h0100});
            repeat (3) @(posedge clk);
            `CHK("irq clear", 1'b0, portIrq)
        end
        wr(8'h14, 32'h0000_0100);
        want[5] <= 1'b1;
        repeat (6) @(posedge clk);
        rc(PCTL_FLAG_ADDR, 32'h0);
        `CHK("irq off", 1'b0, portIrq)
        wr(8'h14, 32'h0109_0100);
        want[5] <= 1'b0;
        wr(PCTL_CTRL_ADDR, 32'h0);
        want[5] <= 1'b1;
        repeat (6) @(posedge clk);
        rc(PCTL_FLAG_ADDR, 32'h0);
        rc(8'h0C, 32'h0009_0146);
        want[5] <= 1'b0;
        wr(PCTL_CTRL_ADDR, 32'h1);
        // Clock keeps running here, so only the wake path is told apart
        stopMode <= 1'b1;
        repeat (4) @(posedge clk);
        want[5] <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK("wakeup", 1'b1, wakeup)
        stopMode <= 1'b0;
        repeat (6) @(posedge clk);
        rc(PCTL_FLAG_ADDR, 32'h20);
        wr(PCTL_FLAG_ADDR, 32'h20);
        print_verdict;
    end
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        print_verdict;
    end
endmodule
